// *** hdl/bcrc_engine.sv ***
// Byte-wide CRC engine with Wishbone registers and an automatic flash walk.
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bcrc_regs.svh"

module bcrc_engine #(
  parameter int PAGE_W = 7,
  parameter int COUNT_W = 8,
  parameter int FADDR_W = 16,
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash read port.
  output logic flash_req,
  output logic [FADDR_W-1:0] flash_addr,
  input wire logic flash_gnt,
  input wire logic [7:0] flash_rdata,
  input wire logic flash_rvalid,
  output logic flash_rready,
  // Processor stall.
  output logic cpu_hold
);

  localparam int TOT_W = COUNT_W + `BCRC_SECTOR_SHIFT;

  // Bus acknowledge and read data registers.
  logic ack_reg;
  logic [31:0] dat_reg;
  // Software visible configuration.
  logic poly_select_reg;
  logic init_value_select_reg;
  logic [1:0] result_byte_pointer_reg;
  logic [7:0] crc_input_byte_reg;
  logic auto_flash_enable_reg;
  logic [PAGE_W-1:0] start_page_reg;
  logic [COUNT_W-1:0] sector_count_reg;
  // Running CRC result, full 32 bits held in both modes.
  logic [31:0] result_reg;
  logic [31:0] result_next;
  // Bit steps left for the byte being folded in.
  logic [3:0] steps_reg;
  // Automatic walk state, bytes delivered and flash address.
  bcrc_pkg::bcrc_auto_e auto_reg;
  bcrc_pkg::bcrc_auto_e auto_next;
  logic [TOT_W-1:0] done_bytes_reg;
  logic [FADDR_W-1:0] addr_reg;

  // Buffer connections.
  logic buf_in_valid;
  logic buf_in_ready;
  logic [7:0] buf_in_data;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;

  // Address decode.
  wire hit_ctrl = (wb_adr_i == `BCRC_CTRL_OFS);
  wire hit_input = (wb_adr_i == `BCRC_INPUT_OFS);
  wire hit_result = (wb_adr_i == `BCRC_RESULT_OFS);
  wire hit_auto = (wb_adr_i == `BCRC_AUTO_OFS);
  wire hit_count = (wb_adr_i == `BCRC_COUNT_OFS);
  wire lane0 = wb_sel_i[0];

  // A new request is one not yet answered.
  wire req_new = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire busy = (auto_reg != bcrc_pkg::BCRC_IDLE);
  // The engine is quiet when no byte waits and no step is pending.
  wire engine_quiet = ~buf_out_valid & (steps_reg == 4'h0);

  // Input writes wait for buffer room; result and control access wait for
  // the engine so that a read sees every byte already written.
  wire need_room = hit_input & wb_we_i;
  wire need_quiet = hit_ctrl | hit_result;
  wire can_take = ~busy & (~need_room | buf_in_ready) & (~need_quiet | engine_quiet);
  wire take = req_new & can_take;

  // Qualified accesses.
  wire wr_ctrl_any = take & hit_ctrl & wb_we_i;
  wire wr_ctrl = wr_ctrl_any & lane0;
  wire wr_input = take & hit_input & wb_we_i & lane0;
  wire wr_result = take & hit_result & wb_we_i & lane0;
  wire acc_result = take & hit_result;
  wire wr_auto = take & hit_auto & wb_we_i & lane0;
  wire wr_count = take & hit_count & wb_we_i & lane0;
  wire init_hit = wr_ctrl & wb_dat_i[`BCRC_CTRL_INIT_BIT];

  // Start of a flash walk on any control write while enabled.
  wire start_auto = wr_ctrl_any & auto_flash_enable_reg;

  // Visible result width follows the polynomial select.
  wire [31:0] result_view = poly_select_reg ? {16'h0000, result_reg[15:0]} : result_reg;
  // Byte index into the result; 16-bit mode folds codes 2 and 3 back.
  wire [1:0] byte_idx = poly_select_reg ? {1'b0, result_byte_pointer_reg[0]} : result_byte_pointer_reg;
  wire [7:0] result_byte = result_view[{byte_idx, 3'b000} +: 8];

  // Preload value from the value select bit.
  wire [31:0] preload = wb_dat_i[`BCRC_CTRL_VAL_BIT] ? `BCRC_PRELOAD_ONES : `BCRC_PRELOAD_ZERO;

  // Read data selection; unmapped addresses read as zero.
  wire [7:0] ctrl_rd = {3'b000, poly_select_reg, 1'b0, init_value_select_reg, result_byte_pointer_reg};
  wire [7:0] auto_rd = {auto_flash_enable_reg, start_page_reg};
  wire [31:0] rd_word = hit_ctrl ? {24'h000000, ctrl_rd} :
                        hit_input ? {24'h000000, crc_input_byte_reg} :
                        hit_result ? {24'h000000, result_byte} :
                        hit_auto ? {24'h000000, auto_rd} :
                        hit_count ? {{(32 - COUNT_W){1'b0}}, sector_count_reg} :
                        32'h00000000;

  // Flash walk helpers: total bytes and start address in 512-byte sectors.
  wire [TOT_W-1:0] total_bytes = {sector_count_reg, {`BCRC_SECTOR_SHIFT{1'b0}}};
  wire [FADDR_W-1:0] base_addr = FADDR_W'({start_page_reg, {`BCRC_SECTOR_SHIFT{1'b0}}});
  wire flash_push = (auto_reg == bcrc_pkg::BCRC_WAIT) & flash_rvalid & buf_in_ready;
  wire last_byte = (done_bytes_reg + 1'b1) == total_bytes;

  // Buffer feed: flash bytes during a walk, bus input writes otherwise.
  assign buf_in_valid = busy ? flash_push : wr_input;
  assign buf_in_data = busy ? flash_rdata : wb_dat_i[7:0];
  // The engine drains one byte only when its bit steps are finished.
  assign buf_out_ready = (steps_reg == 4'h0);

  // Bus and flash outputs.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign flash_req = (auto_reg == bcrc_pkg::BCRC_ISSUE);
  assign flash_addr = addr_reg;
  assign flash_rready = (auto_reg == bcrc_pkg::BCRC_WAIT) & buf_in_ready;
  assign cpu_hold = busy;

  // Two-entry buffer between the byte sources and the CRC engine.
  bcrc_fifo #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // Result update: init, port overwrite, byte load or one bit step.
  always_comb begin
    result_next = result_reg;
    if (init_hit) begin
      result_next = preload;
    end else if (wr_result) begin
      result_next[{byte_idx, 3'b000} +: 8] = wb_dat_i[7:0];
    end else if (buf_out_valid && buf_out_ready) begin
      if (poly_select_reg) begin
        result_next[15:8] = result_reg[15:8] ^ buf_out_data;
      end else begin
        result_next[7:0] = result_reg[7:0] ^ buf_out_data;
      end
    end else if (steps_reg != 4'h0) begin
      if (poly_select_reg) begin
        // Left shift, polynomial in when the old top bit was set.
        result_next[15:0] = {result_reg[14:0], 1'b0} ^
                            (result_reg[15] ? `BCRC_POLY16 : 16'h0000);
      end else begin
        // Reflected right shift with the reversed polynomial.
        result_next = {1'b0, result_reg[31:1]} ^
                      (result_reg[0] ? `BCRC_POLY32_REFL : 32'h00000000);
      end
    end
  end

  // Walk state sequencing.
  always_comb begin
    auto_next = auto_reg;
    case (auto_reg)
      bcrc_pkg::BCRC_IDLE: begin
        // A zero sector count walks nothing and releases at once.
        if (start_auto && (sector_count_reg != '0)) begin
          auto_next = bcrc_pkg::BCRC_ISSUE;
        end
      end
      bcrc_pkg::BCRC_ISSUE: begin
        // One read in flight at a time keeps the buffer from overrunning.
        if (flash_gnt) begin
          auto_next = bcrc_pkg::BCRC_WAIT;
        end
      end
      bcrc_pkg::BCRC_WAIT: begin
        if (flash_push) begin
          auto_next = last_byte ? bcrc_pkg::BCRC_DRAIN : bcrc_pkg::BCRC_ISSUE;
        end
      end
      bcrc_pkg::BCRC_DRAIN: begin
        // The processor stays held until the last byte is folded in.
        if (engine_quiet) begin
          auto_next = bcrc_pkg::BCRC_IDLE;
        end
      end
      default: begin
        auto_next = bcrc_pkg::BCRC_IDLE;
      end
    endcase
  end

  // Bus answer: one acknowledge per request, data captured with it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= take;
      if (take) begin
        dat_reg <= rd_word;
      end
    end
  end

  // Control fields; the init strobe itself is never stored.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      poly_select_reg <= 1'b0;
      init_value_select_reg <= 1'b0;
      result_byte_pointer_reg <= 2'b00;
    end else if (wr_ctrl) begin
      poly_select_reg <= wb_dat_i[`BCRC_CTRL_SEL_BIT];
      init_value_select_reg <= wb_dat_i[`BCRC_CTRL_VAL_BIT];
      result_byte_pointer_reg <= wb_dat_i[`BCRC_CTRL_PTR_HI:`BCRC_CTRL_PTR_LO];
    end else if (acc_result) begin
      result_byte_pointer_reg <= result_byte_pointer_reg + 2'b01;
    end
  end

  // Input byte, auto control and sector count registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_input_byte_reg <= `BCRC_INPUT_RST;
      auto_flash_enable_reg <= 1'b0;
      start_page_reg <= '0;
      sector_count_reg <= '0;
    end else begin
      if (wr_input) begin
        crc_input_byte_reg <= wb_dat_i[7:0];
      end
      if (wr_auto) begin
        auto_flash_enable_reg <= wb_dat_i[`BCRC_AUTO_EN_BIT];
        start_page_reg <= wb_dat_i[PAGE_W-1:0];
      end
      if (wr_count) begin
        sector_count_reg <= wb_dat_i[COUNT_W-1:0];
      end
    end
  end

  // Result register and bit step counter.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg <= `BCRC_RESULT_RST;
      steps_reg <= 4'h0;
    end else begin
      result_reg <= result_next;
      if (buf_out_valid && buf_out_ready) begin
        steps_reg <= `BCRC_STEPS_PER_BYTE;
      end else if (steps_reg != 4'h0) begin
        steps_reg <= steps_reg - 4'h1;
      end
    end
  end

  // Walk state, byte count and ascending flash address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_reg <= bcrc_pkg::BCRC_IDLE;
      done_bytes_reg <= '0;
      addr_reg <= '0;
    end else begin
      auto_reg <= auto_next;
      if (start_auto) begin
        done_bytes_reg <= '0;
        addr_reg <= base_addr;
      end else if (flash_push) begin
        done_bytes_reg <= done_bytes_reg + 1'b1;
        addr_reg <= addr_reg + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** hdl/bcrc_regs.svh ***
// Register offsets, field positions, reset values and counts for the byte CRC engine.
`ifndef BCRC_REGS_SVH
`define BCRC_REGS_SVH

// Byte addresses of the word registers on the bus.
`define BCRC_CTRL_OFS 8'h00
`define BCRC_INPUT_OFS 8'h04
`define BCRC_RESULT_OFS 8'h08
`define BCRC_AUTO_OFS 8'h0C
`define BCRC_COUNT_OFS 8'h10

// Control register field positions.
`define BCRC_CTRL_PTR_LO 0
`define BCRC_CTRL_PTR_HI 1
`define BCRC_CTRL_VAL_BIT 2
`define BCRC_CTRL_INIT_BIT 3
`define BCRC_CTRL_SEL_BIT 4

// Auto control register field positions.
`define BCRC_AUTO_EN_BIT 7

// Reset values.
`define BCRC_CTRL_RST 8'h00
`define BCRC_INPUT_RST 8'h00
`define BCRC_AUTO_RST 8'h00
`define BCRC_COUNT_RST 8'h00
`define BCRC_RESULT_RST 32'h00000000

// Preload values.
`define BCRC_PRELOAD_ZERO 32'h00000000
`define BCRC_PRELOAD_ONES 32'hFFFFFFFF

// Polynomials.
`define BCRC_POLY16 16'h1021
`define BCRC_POLY32_REFL 32'hEDB88320

// Bit steps per byte and sector size.
`define BCRC_STEPS_PER_BYTE 4'h8
`define BCRC_SECTOR_SHIFT 9

`endif

// *** hdl/bcrc_pkg.sv ***
// Types shared by the byte CRC engine.
`default_nettype none

package bcrc_pkg;

  // Automatic flash walk states, Gray coded along idle, issue, wait, drain.
  typedef enum logic [1:0] {
    BCRC_IDLE  = 2'b00,
    BCRC_ISSUE = 2'b01,
    BCRC_WAIT  = 2'b11,
    BCRC_DRAIN = 2'b10
  } bcrc_auto_e;

endpackage

`default_nettype wire

// *** hdl/bcrc_fifo.sv ***
// Small ring buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module bcrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Storage words.
  logic [WIDTH-1:0] mem_reg [DEPTH];
  // Write and read positions.
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  // Number of words held.
  logic [PW:0] cnt_reg;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [PW-1:0] wr_inc = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
  wire [PW-1:0] rd_inc = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;

  // Full and empty follow the word count, so ready falls only when full.
  assign in_ready = (cnt_reg != (PW + 1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];

  // Storage is written on each accepted word.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Positions and count move with push and pop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_inc;
      end
      if (pop) begin
        rd_reg <= rd_inc;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** testbench/bcrc_flash_model.sv ***
// Flash memory model that serves the engine's byte reads.
`timescale 1ns/1ps
`default_nettype none

module bcrc_flash_model (
  // Clock, reset and pace.
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  // Read port.
  input wire logic flash_req,
  input wire logic [15:0] flash_addr,
  output logic flash_gnt,
  output logic [7:0] flash_rdata,
  output logic flash_rvalid,
  input wire logic flash_rready
);
  logic busy_reg; // A read is taken and not yet served.
  logic [15:0] addr_reg; // Address of that read.
  logic [1:0] wait_reg; // Wait cycles left.

  // One read at a time: grant, optional delay, then the byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      addr_reg <= 16'h0;
      wait_reg <= 2'h0;
      flash_gnt <= 1'b0;
      flash_rvalid <= 1'b0;
      flash_rdata <= 8'h0;
    end else if (flash_gnt) begin
      // Address is taken at this edge.
      flash_gnt <= 1'b0;
      busy_reg <= 1'b1;
      addr_reg <= flash_addr;
      wait_reg <= slow ? 2'h3 : 2'h0;
    end else if (flash_rvalid) begin
      if (flash_rready) begin
        // Byte taken, so the data lines stop showing it.
        flash_rvalid <= 1'b0;
        flash_rdata <= ~flash_rdata;
        busy_reg <= 1'b0;
        wait_reg <= slow ? 2'h2 : 2'h0;
      end
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end else if (busy_reg) begin
      flash_rvalid <= 1'b1;
      flash_rdata <= addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h3C;
    end else if (flash_req) begin
      flash_gnt <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/bcrc_engine_assertions.sv ***
// Port checker for the byte CRC engine.
`timescale 1ns/1ps
`default_nettype none

module bcrc_engine_chk #(
  parameter int FADDR_W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Flash and stall.
  input wire logic flash_req,
  input wire logic [FADDR_W-1:0] flash_addr,
  input wire logic flash_gnt,
  input wire logic flash_rvalid,
  input wire logic flash_rready,
  input wire logic cpu_hold
);
  // One clock domain for every check.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_width_a: assert property (wb_ack_o && $past(!wb_we_i) |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above byte");
  walk_start_a: assert property ($rose(cpu_hold) |-> $past(wb_we_i && wb_adr_i == 8'h00))
    else $error("walk without control write");
  walk_base_a: assert property ($rose(cpu_hold) |-> flash_req && flash_addr[8:0] == 9'h0)
    else $error("walk not at sector start");
  bus_stall_a: assert property (cpu_hold && $past(cpu_hold) |-> !wb_ack_o)
    else $error("bus answered during walk");
  req_hold_a: assert property (flash_req |-> cpu_hold)
    else $error("flash read while cpu runs");
  addr_stable_a: assert property (flash_req && !flash_gnt |=> flash_req && $stable(flash_addr))
    else $error("flash request dropped");
  addr_step_a: assert property (flash_rvalid && flash_rready |=> flash_addr == $past(flash_addr) + 1'b1)
    else $error("flash address not ascending");

  // Main scenarios.
  cover property ($rose(cpu_hold));
  cover property (wb_ack_o && !wb_we_i);
  cover property (flash_rvalid && !flash_rready);
endmodule

bind bcrc_engine bcrc_engine_chk #(.FADDR_W(FADDR_W)) chk_u (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_req(flash_req),
  .flash_addr(flash_addr), .flash_gnt(flash_gnt), .flash_rvalid(flash_rvalid),
  .flash_rready(flash_rready), .cpu_hold(cpu_hold)
);
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the byte CRC engine.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, rst, slow; // Clock, reset, flash pace.
  logic wb_cyc, wb_stb, wb_we, wb_ack_o; // Bus controls.
  logic [7:0] wb_adr, flash_rdata;
  logic [31:0] wb_dat, wb_dat_o, rd, exp; // Bus data, last read, expectation.
  logic flash_req, flash_gnt, flash_rvalid, flash_rready, cpu_hold;
  logic [15:0] flash_addr, fa;
  int err_count, check_count;
  // One table case: mode, preload, byte count, bytes, result.
  typedef struct {logic sel; logic val; int n; logic [39:0] b; logic [31:0] res;} bcrc_row_s;
  bcrc_row_s rows[8] = '{
    '{1'b1, 1'b1, 1, 40'h63, 32'hBD35}, '{1'b1, 1'b1, 3, 40'hAABBCC, 32'h6CF6},
    '{1'b1, 1'b1, 5, 40'hAABBCC, 32'hB166}, '{1'b1, 1'b0, 1, 40'h0, 32'h0},
    '{1'b0, 1'b1, 1, 40'h63, 32'hF9462090}, '{1'b0, 1'b1, 3, 40'hAABBCC, 32'h41B207B3},
    '{1'b0, 1'b1, 5, 40'hAABBCC, 32'h78D129BC}, '{1'b0, 1'b0, 1, 40'h0, 32'h0}};

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  bcrc_engine dut_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_gnt(flash_gnt), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
    .flash_rready(flash_rready), .cpu_hold(cpu_hold));
  bcrc_flash_model flash_u (.clk(clk), .rst(rst), .slow(slow), .flash_req(flash_req),
    .flash_addr(flash_addr), .flash_gnt(flash_gnt), .flash_rdata(flash_rdata),
    .flash_rvalid(flash_rvalid), .flash_rready(flash_rready));

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic bus cycle; the wait for ack is bounded.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40000);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin
      chk("ack", 32'h1, 32'h0);
      report_and_stop();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  // Reads four result bytes through the pointer.
  task automatic read_res(input logic m, input logic [31:0] e);
    for (int k = 0; k < 4; k++) begin
      wb(1'b0, 8'h08, 32'h0);
      chk("result byte", {24'h0, e[8*(m ? k % 2 : k)+:8]}, rd);
    end
  endtask

  // Reference byte update for either mode.
  function automatic logic [31:0] upd(logic [31:0] c, logic [7:0] b, logic m);
    if (m) begin
      c[15:8] ^= b;
      repeat (8) c[15:0] = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0);
    end else begin
      c[7:0] ^= b;
      repeat (8) c = (c >> 1) ^ (c[0] ? 32'hEDB88320 : 32'h0);
    end
    return c;
  endfunction

  // Main sequence.
  initial begin
    rst = 1'b1;
    slow = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
    err_count = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Table cases: select, preload, init, bytes, then the result.
    foreach (rows[r]) begin
      wb(1'b1, 8'h00, {27'h0, rows[r].sel, 4'h0});
      wb(1'b1, 8'h00, {27'h0, rows[r].sel, 1'b0, rows[r].val, 2'h0});
      wb(1'b1, 8'h00, {27'h0, rows[r].sel, 1'b1, rows[r].val, 2'h0});
      for (int i = 0; i < rows[r].n; i++) begin
        wb(1'b1, 8'h04, {24'h0, rows[r].b[8*(rows[r].n-1-i)+:8]});
      end
      wb(1'b0, 8'h04, 32'h0);
      chk("input byte", {24'h0, rows[r].b[7:0]}, rd);
      read_res(rows[r].sel, rows[r].res);
    end
    // Result port write at pointer 2; the pointer moves on to 3.
    wb(1'b1, 8'h00, 32'h02);
    wb(1'b1, 8'h08, 32'hA5);
    wb(1'b0, 8'h08, 32'h0);
    chk("byte 3", 32'h0, rd);
    wb(1'b1, 8'h00, 32'h02);
    wb(1'b0, 8'h08, 32'h0);
    chk("byte 2", 32'hA5, rd);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    // One-sector flash walk from page 3 against a slow flash.
    slow <= 1'b1;
    wb(1'b1, 8'h00, 32'h0C);
    wb(1'b1, 8'h0C, 32'h83);
    wb(1'b1, 8'h10, 32'h01);
    wb(1'b1, 8'h00, 32'h00);
    chk("hold during walk", 32'h1, {31'h0, cpu_hold});
    wb(1'b1, 8'h0C, 32'h03);
    chk("hold after walk", 32'h0, {31'h0, cpu_hold});
    wb(1'b0, 8'h0C, 32'h0);
    chk("auto control", 32'h03, rd);
    wb(1'b0, 8'h10, 32'h0);
    chk("sector count", 32'h01, rd);
    exp = 32'hFFFFFFFF;
    for (int i = 0; i < 512; i++) begin
      fa = 16'(1536 + i);
      exp = upd(exp, fa[7:0] ^ fa[15:8] ^ 8'h3C, 1'b0);
    end
    read_res(1'b0, exp);
    // A second reset clears the result and the control fields.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk("control", 32'h0, rd);
    read_res(1'b0, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
